// ===== hw/wup_pkg.sv
/*
 * Shared constants for the wireless serial pipe: serial timing, packet
 * sizing, switch line and learn timing, register map and state codes.
 * Assumes a single 100 MHz clock and an APB master with 32-bit data.
 */
package wup_pkg;

	// Clock and serial framing
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned BAUD      = 9600;
	localparam int unsigned BIT_CYC   = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned FIFO_AW   = 4;

	// Packet assembly and timers in their own units
	localparam int unsigned PKT_BYTES  = 12;
	localparam int unsigned FLUSH_MS   = 15;
	localparam int unsigned HOLD_MS    = 20;
	localparam int unsigned SENSE_MS   = 14;
	localparam int unsigned DIP_MS     = 1;
	localparam int unsigned LEARN_S    = 10;
	localparam int unsigned FLUSH_CYC  = FLUSH_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CYC   = HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned SENSE_CYC  = SENSE_MS * (CLK_HZ / 1000);
	localparam int unsigned DIP_CYC    = DIP_MS * (CLK_HZ / 1000);
	localparam int unsigned LEARN_CYC  = LEARN_S * CLK_HZ;

	// Strap code: bit 0 is mode select 0
	localparam logic [2:0] MODE_NET = 3'h3;

	// Register map
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_LEARN_ID = 12'h008;
	localparam logic [11:0] REG_PKT_CNT  = 12'h00C;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_LEARN_BIT = 1;
	localparam logic        CTRL_EN_RST    = 1'h1;
	localparam int unsigned ST_MODE_OK  = 0;
	localparam int unsigned ST_LEARNING = 1;
	localparam int unsigned ST_SW_DRIVE = 2;
	localparam int unsigned ST_TX_ACT   = 3;
	localparam int unsigned ST_SENSE    = 4;
	localparam int unsigned ST_ID_VALID = 5;

	// Radio transmit sequencer
	typedef enum logic [4:0] {
		WUP_TX_IDLE  = 5'h01,
		WUP_TX_RD    = 5'h02,
		WUP_TX_WAIT  = 5'h04,
		WUP_TX_SEND  = 5'h08,
		WUP_TX_EMPTY = 5'h10
	} wup_txs_e;

endpackage : wup_pkg

// ===== hw/wup_mem.sv
/*
 * Small byte buffer with one write and one registered read port.
 * Assumes the caller tracks fill level and never reads an empty slot.
 */
module wup_mem
	import wup_pkg::*;
#(
	parameter int unsigned W  = DATA_BITS,
	parameter int unsigned AW = FIFO_AW
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// Read side
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);

	typedef struct packed {
		logic [(2**AW)-1:0][W-1:0] mem;
		logic [W-1:0]              rd;
	} wup_mem_s;

	wup_mem_s q;
	wup_mem_s n;

	// Write and read, read data held until the next read
	always_comb begin
		n = q;
		if (wr_en) begin
			n.mem[wr_addr] = wr_data;
		end
		if (rd_en) begin
			n.rd = q.mem[rd_addr];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign rd_data = q.rd;

endmodule : wup_mem

// ===== hw/wup_uart_rx.sv
/*
 * Serial receiver, 8 data bits, no parity, stop bit not checked.
 * Assumes the input is synchronous to pclk and idles high.
 */
module wup_uart_rx
	import wup_pkg::*;
#(
	parameter logic [15:0] BIT_CYC_P = 16'(BIT_CYC)
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Serial line
	input  wire logic       rx_in,
	// Received byte
	output logic            byte_valid,
	output logic [7:0]      byte_data
);

	typedef struct packed {
		logic        busy;
		logic        prev;
		logic [15:0] cnt;
		logic [3:0]  bitn;
		logic [7:0]  shift;
		logic        valid;
		logic [7:0]  data;
	} wup_urx_s;

	localparam wup_urx_s URX_RST = '{prev: 1'h1, default: '0};

	wup_urx_s q;
	wup_urx_s n;

	// Start edge, mid-bit sampling, byte out at mid stop bit
	always_comb begin
		n = q;
		n.valid = 1'h0;
		n.prev = rx_in;
		if (!q.busy) begin
			if (q.prev && !rx_in) begin
				n.busy = 1'h1;
				n.cnt = BIT_CYC_P >> 1;
				n.bitn = 4'h0;
			end
		end else if (q.cnt != 16'h0) begin
			n.cnt = q.cnt - 16'h1;
		end else begin
			n.cnt = BIT_CYC_P - 16'h1;
			if (q.bitn == 4'h0) begin
				n.busy = !rx_in; // Glitch rejected
				n.bitn = 4'h1;
			end else if (q.bitn <= 4'h8) begin
				n.shift = {rx_in, q.shift[7:1]};
				n.bitn = q.bitn + 4'h1;
			end else begin
				n.busy = 1'h0;
				n.valid = 1'h1;
				n.data = q.shift;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= URX_RST;
		end else begin
			q <= n;
		end
	end

	assign byte_valid = q.valid;
	assign byte_data = q.data;

endmodule : wup_uart_rx

// ===== hw/wup_top.sv
/*
 * Network-mode wireless serial pipe: packetiser toward the radio, serial
 * replay of received packets, switch line drive and sense, learn mode and
 * an APB register slave. Assumes the radio core moves packets on the
 * rf_tx and rf_rx ports and presents rf_rx only while rf_rx_en is high.
 */
module wup_top
	import wup_pkg::*;
#(
	parameter int unsigned AW        = FIFO_AW,
	parameter logic [15:0] BIT_CYC_P = 16'(BIT_CYC),
	parameter logic [31:0] FLUSH_P   = 32'(FLUSH_CYC),
	parameter logic [31:0] HOLD_P    = 32'(HOLD_CYC),
	parameter logic [31:0] SENSE_P   = 32'(SENSE_CYC),
	parameter logic [31:0] DIP_P     = 32'(DIP_CYC),
	parameter logic [31:0] LEARN_P   = 32'(LEARN_CYC)
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Mode straps
	input  wire logic [2:0]  mode_sel,
	// Host serial
	input  wire logic        ser_in,
	output logic             ser_out,
	// Switch line
	input  wire logic        sw_in,
	output logic             sw_out,
	output logic             sw_oe,
	// Learn and status line
	input  wire logic        learn_in,
	output logic             learn_out,
	output logic             learn_oe,
	// Radio transmit packets
	output logic             rf_tx_valid,
	input  wire logic        rf_tx_ready,
	output logic      [7:0]  rf_tx_data,
	output logic             rf_tx_last,
	output logic             rf_tx_nodata,
	output logic             rf_tx_sw,
	// Radio receive packets
	output logic             rf_rx_en,
	input  wire logic        rf_rx_valid,
	input  wire logic [7:0]  rf_rx_data,
	input  wire logic        rf_rx_last,
	input  wire logic        rf_rx_nodata,
	input  wire logic        rf_rx_sw,
	input  wire logic [31:0] rf_rx_id
);

	typedef struct packed {
		logic          started;
		logic          mode_ok;
		logic          en;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		logic [AW-1:0] tx_wp;
		logic [AW-1:0] tx_rp;
		logic [AW:0]   tx_cnt;
		logic [AW:0]   tx_left;
		logic [31:0]   flush_cnt;
		logic          flush_arm;
		wup_txs_e      tst;
		logic          rf_tx_valid;
		logic [7:0]    rf_tx_data;
		logic          rf_tx_last;
		logic          rf_tx_nodata;
		logic          rf_tx_sw;
		logic          rf_rx_en;
		logic [AW-1:0] rx_wp;
		logic [AW-1:0] rx_rp;
		logic [AW:0]   rx_cnt;
		logic          rx_go;
		logic          ser_busy;
		logic          ser_ld;
		logic [9:0]    ser_shift;
		logic [3:0]    ser_bit;
		logic [15:0]   ser_cnt;
		logic          ser_out;
		logic          sw_drive;
		logic          dip;
		logic          sense_high;
		logic [31:0]   hold_cnt;
		logic [31:0]   per_cnt;
		logic          learn_prev;
		logic          learning;
		logic [31:0]   learn_cnt;
		logic          id_valid;
		logic [31:0]   learned_id;
		logic [31:0]   pkt_cnt;
	} wup_top_s;

	localparam wup_top_s TOP_RST = '{en: CTRL_EN_RST, tst: WUP_TX_IDLE,
		ser_out: 1'h1, default: '0};

	wup_top_s q;
	wup_top_s n;

	logic          active;
	logic          apb_done;
	logic          ctrl_wr;
	logic          sw_loc;
	logic          push;
	logic          pop;
	logic          tx_rd_en;
	logic          rx_take;
	logic          rx_push;
	logic          rx_end;
	logic          ser_issue;
	logic          ser_load;
	logic [AW:0]   len;
	logic [31:0]   status_w;
	logic          rxb_valid;
	logic [7:0]    rxb_data;
	logic [7:0]    tx_rdata;
	logic [7:0]    rx_rdata;

	// Host serial input receiver
	wup_uart_rx #(.BIT_CYC_P(BIT_CYC_P)) u_urx (
		.pclk       (pclk),
		.presetn    (presetn),
		.rx_in      (ser_in),
		.byte_valid (rxb_valid),
		.byte_data  (rxb_data)
	);

	// Bytes waiting to go over the air
	wup_mem #(.W(8), .AW(AW)) u_txbuf (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (push),
		.wr_addr (q.tx_wp),
		.wr_data (rxb_data),
		.rd_en   (tx_rd_en),
		.rd_addr (q.tx_rp),
		.rd_data (tx_rdata)
	);

	// Bytes received over the air waiting for the serial output
	wup_mem #(.W(8), .AW(AW)) u_rxbuf (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (rx_push),
		.wr_addr (q.rx_wp),
		.wr_data (rf_rx_data),
		.rd_en   (ser_issue),
		.rd_addr (q.rx_rp),
		.rd_data (rx_rdata)
	);

	// All next-state logic
	always_comb begin
		n = q;
		len = '0;
		status_w = '0;
		pop = 1'h0;
		tx_rd_en = 1'h0;
		// Straps are caught once, on the first edge after release
		if (!q.started) begin
			n.started = 1'h1;
			n.mode_ok = (mode_sel == MODE_NET);
		end
		active = q.mode_ok && q.en;
		sw_loc = sw_in && !q.sw_drive;
		push = rxb_valid && active && !q.tx_cnt[AW];
		rx_take = rf_rx_valid && q.rf_rx_en;
		rx_push = rx_take && !rf_rx_nodata && !q.rx_cnt[AW];
		rx_end = rx_take && rf_rx_last;
		// APB: one wait state, write lands on the completing edge
		status_w[ST_MODE_OK] = q.mode_ok;
		status_w[ST_LEARNING] = q.learning;
		status_w[ST_SW_DRIVE] = q.sw_drive;
		status_w[ST_TX_ACT] = !q.rf_rx_en;
		status_w[ST_SENSE] = q.sense_high;
		status_w[ST_ID_VALID] = q.id_valid;
		apb_done = psel && penable && q.pready;
		ctrl_wr = apb_done && pwrite && (paddr == REG_CTRL);
		n.pready = psel && penable && !q.pready;
		n.pslverr = 1'h0;
		if (psel && penable && !q.pready) begin
			case (paddr)
				REG_CTRL: n.prdata = {31'h0, q.en};
				REG_STATUS: n.prdata = status_w;
				REG_LEARN_ID: n.prdata = q.learned_id;
				REG_PKT_CNT: n.prdata = q.pkt_cnt;
				default: begin
					n.prdata = 32'h0;
					n.pslverr = 1'h1;
				end
			endcase
		end
		if (ctrl_wr) begin
			n.en = pwdata[CTRL_EN_BIT];
		end
		// Radio transmit sequencer
		case (q.tst)
			WUP_TX_IDLE: begin
				if (active && (q.tx_cnt >= (AW+1)'(PKT_BYTES) ||
				    (q.flush_arm && q.flush_cnt == 32'h0 &&
				    q.tx_cnt != '0))) begin
					len = (q.tx_cnt > (AW+1)'(PKT_BYTES)) ?
						(AW+1)'(PKT_BYTES) : q.tx_cnt;
					n.tx_left = len;
					n.flush_arm = (q.tx_cnt > len);
					n.tst = WUP_TX_RD;
				end else if (active && sw_loc) begin
					n.rf_tx_valid = 1'h1;
					n.rf_tx_last = 1'h1;
					n.rf_tx_nodata = 1'h1;
					n.rf_tx_sw = 1'h1;
					n.tst = WUP_TX_EMPTY;
				end
			end
			WUP_TX_RD: begin
				tx_rd_en = 1'h1;
				n.tst = WUP_TX_WAIT;
			end
			WUP_TX_WAIT: begin
				n.rf_tx_data = tx_rdata;
				n.rf_tx_valid = 1'h1;
				n.rf_tx_last = (q.tx_left == (AW+1)'(1));
				n.rf_tx_nodata = 1'h0;
				n.rf_tx_sw = sw_loc;
				n.tst = WUP_TX_SEND;
			end
			WUP_TX_SEND: begin
				if (rf_tx_ready) begin
					n.rf_tx_valid = 1'h0;
					pop = 1'h1;
					n.tx_left = q.tx_left - (AW+1)'(1);
					n.tst = q.rf_tx_last ? WUP_TX_IDLE : WUP_TX_RD;
					n.pkt_cnt = q.pkt_cnt + {31'h0, q.rf_tx_last};
				end
			end
			WUP_TX_EMPTY: begin
				if (rf_tx_ready) begin
					n.rf_tx_valid = 1'h0;
					n.pkt_cnt = q.pkt_cnt + 32'h1;
					n.tst = WUP_TX_IDLE;
				end
			end
			default: begin
				n.rf_tx_valid = 1'h0;
				n.tst = WUP_TX_IDLE;
			end
		endcase
		// Flush timer restarts on every byte pushed into the transmit buffer
		if (push) begin
			n.flush_cnt = FLUSH_P - 32'h1;
			n.flush_arm = 1'h1;
		end else if (q.flush_arm && q.flush_cnt != 32'h0) begin
			n.flush_cnt = q.flush_cnt - 32'h1;
		end
		n.tx_wp = q.tx_wp + AW'(push);
		n.tx_rp = q.tx_rp + AW'(pop);
		n.tx_cnt = q.tx_cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Listen only while nothing is queued or sent
		n.rf_rx_en = n.mode_ok && n.en && n.tst == WUP_TX_IDLE &&
			n.tx_cnt == '0 && !sw_loc;
		// Serial replay, next byte fetched during the stop bit
		ser_issue = !q.ser_ld && q.rx_go && q.rx_cnt != '0 &&
			(!q.ser_busy || q.ser_bit == 4'h9);
		ser_load = q.ser_ld && (!q.ser_busy ||
			(q.ser_bit == 4'h9 && q.ser_cnt == 16'h0));
		if (ser_issue) begin
			n.ser_ld = 1'h1;
		end
		if (ser_load) begin
			n.ser_shift = {1'h1, rx_rdata, 1'h0};
			n.ser_busy = 1'h1;
			n.ser_bit = 4'h0;
			n.ser_cnt = BIT_CYC_P - 16'h1;
			n.ser_ld = 1'h0;
		end else if (q.ser_busy) begin
			if (q.ser_cnt != 16'h0) begin
				n.ser_cnt = q.ser_cnt - 16'h1;
			end else if (q.ser_bit == 4'h9) begin
				n.ser_busy = 1'h0;
			end else begin
				n.ser_bit = q.ser_bit + 4'h1;
				n.ser_shift = {1'h1, q.ser_shift[9:1]};
				n.ser_cnt = BIT_CYC_P - 16'h1;
			end
		end
		n.ser_out = n.ser_busy ? n.ser_shift[0] : 1'h1;
		n.rx_wp = q.rx_wp + AW'(rx_push);
		n.rx_rp = q.rx_rp + AW'(ser_issue);
		n.rx_cnt = q.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(ser_issue);
		if (n.rx_cnt == '0) begin
			n.rx_go = 1'h0;
		end
		if (rx_end) begin
			n.rx_go = 1'h1;
		end
		// Switch line drive, hold-off and periodic sense
		if (rx_end && rf_rx_sw) begin
			if (!q.sw_drive) begin
				n.per_cnt = SENSE_P - 32'h1;
				n.dip = 1'h0;
			end
			n.sw_drive = 1'h1;
			n.hold_cnt = HOLD_P - 32'h1;
		end else if (rx_end) begin
			n.sw_drive = 1'h0;
			n.dip = 1'h0;
		end else if (q.sw_drive) begin
			if (q.hold_cnt == 32'h0) begin
				n.sw_drive = 1'h0;
				n.dip = 1'h0;
			end else begin
				n.hold_cnt = q.hold_cnt - 32'h1;
			end
			if (q.per_cnt != 32'h0) begin
				n.per_cnt = q.per_cnt - 32'h1;
			end else if (!q.dip) begin
				n.dip = 1'h1;
				n.per_cnt = DIP_P - 32'h1;
			end else begin
				n.dip = 1'h0;
				n.sense_high = sw_in;
				n.per_cnt = SENSE_P - 32'h1;
			end
		end
		// Learn mode starts at the end of the host pulse
		n.learn_prev = q.learning ? 1'h0 : learn_in;
		if (!q.learning && active && ((q.learn_prev && !learn_in) ||
		    (ctrl_wr && pwdata[CTRL_LEARN_BIT]))) begin
			n.learning = 1'h1;
			n.learn_cnt = LEARN_P - 32'h1;
		end else if (q.learning) begin
			if (rx_end) begin
				n.learning = 1'h0;
				n.learned_id = rf_rx_id;
				n.id_valid = 1'h1;
			end else if (q.learn_cnt == 32'h0) begin
				n.learning = 1'h0;
			end else begin
				n.learn_cnt = q.learn_cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= TOP_RST;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state register, except sw_oe which gates sw_drive with dip
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign ser_out = q.ser_out;
	assign sw_out = q.sw_drive;
	assign sw_oe = q.sw_drive && !q.dip;
	assign learn_out = q.learning;
	assign learn_oe = q.learning;
	assign rf_tx_valid = q.rf_tx_valid;
	assign rf_tx_data = q.rf_tx_data;
	assign rf_tx_last = q.rf_tx_last;
	assign rf_tx_nodata = q.rf_tx_nodata;
	assign rf_tx_sw = q.rf_tx_sw;
	assign rf_rx_en = q.rf_rx_en;

	// Checks on the design's own behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_idle_high;
		!q.ser_busy |-> ser_out;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("serial out not idle high");

	property p_deaf_tx;
		(q.tst != WUP_TX_IDLE || rf_tx_valid) |-> !rf_rx_en;
	endproperty
	a_deaf_tx: assert property (p_deaf_tx)
		else $error("radio listens while sending");

	property p_listen;
		(q.mode_ok && q.en && q.tst == WUP_TX_IDLE && q.tx_cnt == '0 &&
		!rxb_valid && !sw_in && !q.sw_drive && !ctrl_wr) |=> rf_rx_en;
	endproperty
	a_listen: assert property (p_listen)
		else $error("radio not listening while idle");

	property p_sw_tx;
		(active && q.tst == WUP_TX_IDLE && q.tx_cnt == '0 && sw_loc)
		|=> rf_tx_valid && rf_tx_sw && rf_tx_nodata;
	endproperty
	a_sw_tx: assert property (p_sw_tx)
		else $error("switch high did not start a packet");

	property p_sw_drive;
		(rx_end && rf_rx_sw && !q.dip) |=> sw_out && sw_oe;
	endproperty
	a_sw_drive: assert property (p_sw_drive)
		else $error("switch line not driven after high packet");

	property p_sw_rel;
		(rx_end && !rf_rx_sw) or (q.sw_drive && q.hold_cnt == 32'h0 &&
		!rx_end) |=> !sw_out && !sw_oe;
	endproperty
	a_sw_rel: assert property (p_sw_rel)
		else $error("switch line not released");

	property p_dip;
		(q.sw_drive && !q.dip && q.per_cnt == 32'h0 && q.hold_cnt != 32'h0
		&& !rx_end) |=> !sw_oe && sw_out;
	endproperty
	a_dip: assert property (p_dip)
		else $error("sense dip missing");

	property p_full;
		(active && q.tst == WUP_TX_IDLE && q.tx_cnt >= (AW+1)'(PKT_BYTES))
		|=> q.tst == WUP_TX_RD ##2 rf_tx_valid;
	endproperty
	a_full: assert property (p_full)
		else $error("full packet not sent");

	property p_b2b;
		(q.ser_busy && q.ser_bit == 4'h9 && q.ser_cnt == 16'h0 && q.ser_ld)
		|=> !ser_out && q.ser_busy;
	endproperty
	a_b2b: assert property (p_b2b)
		else $error("gap between replayed bytes");

	property p_learn_to;
		(q.learning && q.learn_cnt == 32'h0 && !rx_end) |=> !learn_oe;
	endproperty
	a_learn_to: assert property (p_learn_to)
		else $error("learn mode did not time out");

	c_pkt: cover property (rf_tx_valid && rf_tx_ready && rf_tx_last);
	c_drive: cover property (q.sw_drive && q.dip);
	c_learn: cover property (q.learning && rx_end);
	c_b2b: cover property (ser_load && q.ser_busy);

endmodule : wup_top

// ===== dv/wup_host_model.sv
/* Host model: 8N1 serial sender and a receiver that queues bytes.
 * Assumes the bit time in clock cycles is given by BITC. */
module wup_host_model #(
	parameter int BITC = 16
) (
	// Clock
	input  wire logic pclk,
	// Serial pins
	output logic      ser_tx,
	input  wire logic ser_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rxq[$];
	logic [7:0] sh;
	int         nrx = 0;

	// Unused input rests high
	initial ser_tx = 1'b1;

	// Start bit, data LSB first, one stop bit
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			ser_tx <= f[i];
			repeat (BITC - 1) @(posedge pclk);
		end
	endtask : send

	// Receiver sampling at mid bit
	initial begin
		forever begin
			@(negedge ser_rx);
			repeat (BITC / 2) @(posedge pclk);
			for (int i = 0; i < 8; i++) begin
				repeat (BITC) @(posedge pclk);
				sh = {ser_rx, sh[7:1]};
			end
			rxq.push_back(sh);
			nrx++;
			repeat (BITC) @(posedge pclk); // Now in the stop bit
		end
	end
endmodule : wup_host_model

// ===== dv/tb_wup_top.sv
/* Self-checking bench for the wireless serial pipe top.
 * Assumes shortened timers; the radio core is mimicked here. */
module tb_wup_top;
	import wup_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BC = 16;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd, id;
	logic        pready, pslverr, er, ser_in, ser_out, sw_out, sw_oe;
	logic        learn_out, learn_oe, rf_tx_valid, rf_tx_last;
	logic        rf_tx_nodata, rf_tx_sw, rf_rx_en, nd, swb, lb;
	logic        host_sw = 0;
	logic        host_learn = 0;
	logic        rf_tx_ready = 0;
	logic        rf_rx_valid = 0;
	logic        rf_rx_last = 0;
	logic        rf_rx_nodata = 0;
	logic        rf_rx_sw = 0;
	logic [7:0]  rf_tx_data, b;
	logic [7:0]  rf_rx_data = '0;
	logic [31:0] rf_rx_id = '0;
	logic [2:0]  mode_sel = MODE_NET;
	logic [7:0]  txq[$], expq[$], sent[$];
	int          num_errors = 0;
	int          tests_run = 0;
	int          npk = 0;
	int          osh = 0;
	int          n;
	wire logic   sw_line = sw_oe ? sw_out : host_sw;
	wire logic   learn_line = learn_oe ? learn_out : host_learn;

	// Clock
	always #5 pclk = ~pclk;

	// Design and host
	wup_top #(.BIT_CYC_P(16'(BC)), .FLUSH_P(32'd2000), .HOLD_P(32'd3000),
		.SENSE_P(32'd1000), .DIP_P(32'd100), .LEARN_P(32'd5000))
		wup_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .mode_sel, .ser_in, .ser_out,
		.sw_in(sw_line), .sw_out, .sw_oe, .learn_in(learn_line), .learn_out,
		.learn_oe, .rf_tx_valid, .rf_tx_ready, .rf_tx_data, .rf_tx_last,
		.rf_tx_nodata, .rf_tx_sw, .rf_rx_en, .rf_rx_valid, .rf_rx_data,
		.rf_rx_last, .rf_rx_nodata, .rf_rx_sw, .rf_rx_id);
	wup_host_model #(.BITC(BC)) wup_host_model_inst (.pclk,
		.ser_tx(ser_in), .ser_rx(ser_out));

	// Radio core: random stalls, keeps accepted beats
	always @(posedge pclk) begin
		rf_tx_ready <= 1'($urandom);
		if (rf_tx_valid && rf_tx_ready) begin
			chk(32'(rf_rx_en), '0);
			if (!rf_tx_nodata) txq.push_back(rf_tx_data);
			{lb, nd, swb} <= {rf_tx_last, rf_tx_nodata, rf_tx_sw};
			if (rf_tx_last) npk <= npk + 1;
		end
	end

	// Retriggerable one-shot that bridges the sense dips
	always @(posedge pclk) begin
		osh <= (sw_oe && sw_out) ? 200 : (osh > 0 ? osh - 1 : 0);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) num_errors++;
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	// Bounded wait on packet count or host byte count
	task automatic waitc(input bit h, input int k);
		n = 0;
		while ((h ? wup_host_model_inst.nrx : npk) < k && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n < 4000), 32'h1);
	endtask : waitc

	// Radio delivers one packet; nb 0 means a no-data beat
	task automatic rf_pkt(input int nb, input logic s, input logic [31:0] i);
		for (int k = 0; rf_rx_en !== 1'b1 && k < 4000; k++) @(posedge pclk);
		chk(32'(rf_rx_en), 32'h1);
		for (int j = 0; j < (nb ? nb : 1); j++) begin
			@(posedge pclk);
			b = 8'($urandom);
			if (nb) expq.push_back(b);
			rf_rx_valid <= 1;
			rf_rx_data <= b;
			rf_rx_nodata <= (nb == 0);
			rf_rx_last <= (j == (nb ? nb : 1) - 1);
			rf_rx_sw <= s;
			rf_rx_id <= i;
		end
		@(posedge pclk);
		rf_rx_valid <= 0;
		rf_rx_data <= ~b;
	endtask : rf_pkt

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// Watchdog
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		stop_test();
	end

	// Main sequence
	initial begin
		void'($urandom(79324));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		apb(REG_CTRL, 0, '0);
		chk(rd, 32'h1);
		apb(REG_STATUS, 0, '0);
		chk(rd & 32'h9, 32'h1);
		apb(12'h010, 0, '0);
		chk(32'(er), 32'h1);
		apb(REG_PKT_CNT, 1, '1);
		apb(REG_PKT_CNT, 0, '0);
		chk(rd, '0);
		// Twelve back to back bytes form one packet
		for (int j = 0; j < 12; j++) begin
			sent.push_back(8'($urandom));
			wup_host_model_inst.send(sent[j]);
		end
		waitc(0, 1);
		chk(32'(lb), 32'h1);
		for (int j = 0; j < 12; j++) chk(32'(txq[j]), 32'(sent[j]));
		// Short burst leaves only after the idle time
		txq.delete();
		wup_host_model_inst.send(8'h00);
		wup_host_model_inst.send(8'hFF);
		repeat (1500) @(posedge pclk);
		chk(txq.size(), 0);
		waitc(0, 2);
		chk(32'({txq[0], txq[1]}), 32'h00FF);
		apb(REG_PKT_CNT, 0, '0);
		chk(rd, 32'h2);
		// Remote switch high, replay and dip
		rf_pkt(3, 1, $urandom);
		repeat (2) @(posedge pclk);
		chk(32'(sw_oe & sw_out), 32'h1);
		waitc(1, 3);
		chk(32'(n <= 32 * BC), 32'h1);
		for (int j = 0; j < 3; j++) begin
			chk(32'(wup_host_model_inst.rxq[j]), 32'(expq[j]));
		end
		for (n = 0; sw_oe === 1'b1 && n < 1100; n++) @(posedge pclk);
		for (n = 0; sw_oe === 1'b0 && n < 200; n++) @(posedge pclk);
		chk(32'(n >= 95 && n <= 105), 32'h1);
		chk(32'(osh > 0), 32'h1);
		apb(REG_STATUS, 0, '0);
		chk(rd & 32'h14, 32'h4);
		rf_pkt(0, 0, '0);
		repeat (2) @(posedge pclk);
		chk(32'(sw_oe), '0);
		rf_pkt(0, 1, '0);
		repeat (2950) @(posedge pclk);
		chk(32'(sw_oe), 32'h1);
		repeat (200) @(posedge pclk);
		chk(32'(sw_oe), '0);
		// Local switch sends no-data packets while high
		host_sw <= 1;
		waitc(0, npk + 2);
		chk(32'({nd, swb}), 32'h3);
		chk(txq.size(), 2);
		host_sw <= 0;
		// Learn by pulse, capture on packet; then by register, timeout
		host_learn <= 1;
		repeat (5) @(posedge pclk);
		host_learn <= 0;
		repeat (3) @(posedge pclk);
		chk(32'({learn_oe, learn_out}), 32'h3);
		id = $urandom;
		rf_pkt(1, 0, id);
		repeat (3) @(posedge pclk);
		chk(32'(learn_oe), '0);
		apb(REG_LEARN_ID, 0, '0);
		chk(rd, id);
		apb(REG_CTRL, 1, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'(learn_oe), 32'h1);
		repeat (5100) @(posedge pclk);
		chk(32'(learn_oe), '0);
		// Wrong straps at a second reset leave the block inert
		presetn <= 0;
		mode_sel <= MODE_NET ^ 3'(1 + $urandom % 7);
		host_sw <= 1'($urandom);
		repeat (3) @(posedge pclk);
		presetn <= 1;
		n = npk;
		repeat (300) @(posedge pclk);
		apb(REG_STATUS, 0, '0);
		chk(rd & 32'h9, 32'h8);
		chk(32'(npk), 32'(n));
		stop_test();
	end
endmodule : tb_wup_top
